// ==== src/spx_defines.svh ====
// constants shared by both ends of the serial shift port
// Summary of operation
// - master select clear makes the port a slave
// - master holds select low through whole transfer
// - slave assembles byte, moves it, sets receive-full
// - slave takes any clock up to sampling limit
// - late write resends byte left in shift register
// - no shift load during transfer; buffer waits
// - phase one starts on edge, zero on select
// - polarity and phase bits pick four formats
// - disable port before changing phase or polarity
// - slave drives its data line only when selected
// - a master keeps its own select high
// - phase zero: select fall drives msb at once
// - phase zero: select toggles between every byte
// - phase one: first edge starts, drives msb
// - phase one: select may stay low between bytes
// - master write starts; phase sets first half
// - bit clock divider runs only when enabled master
// - generated clock edges fall on divider ticks
// - master start delay at most one bit time
// - select rising mid transfer flags mode fault
// - status read then data read clears receive-full
`ifndef SPX_DEFINES_SVH
`define SPX_DEFINES_SVH

`define SPX_BITS        4'h8
`define SPX_LAST_PH     5'h10
`define SPX_RATE_BY2    2'h0
`define SPX_RATE_BY8    2'h1
`define SPX_RATE_BY32   2'h2
`define SPX_RATE_BY128  2'h3
`define SPX_HALF_BY2    7'h01
`define SPX_HALF_BY8    7'h04
`define SPX_HALF_BY32   7'h10
`define SPX_HALF_BY128  7'h40
`define SPX_FAR_HALF    5'h08

`endif

// ==== src/spx_pkg.sv ====
// types shared by both ends of the serial shift port
`default_nettype none
package spx_pkg;
  typedef logic [7:0] spx_byte_t;
  typedef enum logic [2:0] {
    R_IDLE,
    R_SETUP,
    R_SHIFT,
    R_GAP,
    R_REL
  } spx_rstate_e;
endpackage
`default_nettype wire

// ==== src/spx_if.sv ====
// serial link between the port and the remote master, with wire resolution
`default_nettype none
interface spx_if;
  logic dev_sck_o;
  logic dev_sck_oe;
  logic dev_mosi_o;
  logic dev_mosi_oe;
  logic dev_miso_o;
  logic dev_miso_oe;
  logic far_sck_o;
  logic far_sck_oe;
  logic far_mosi_o;
  logic far_mosi_oe;
  logic far_ss_n;
  logic sck;
  logic mosi;
  logic miso;
  logic ss_n;

  // undriven lines read as pulled up
  assign sck  = dev_sck_oe ? dev_sck_o : (far_sck_oe ? far_sck_o : 1'b1);
  assign mosi = dev_mosi_oe ? dev_mosi_o : (far_mosi_oe ? far_mosi_o : 1'b1);
  assign miso = dev_miso_oe ? dev_miso_o : 1'b1;
  assign ss_n = far_ss_n;

  modport dev (
    output dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe, dev_miso_o, dev_miso_oe,
    input  sck, mosi, miso, ss_n
  );
  modport far (
    output far_sck_o, far_sck_oe, far_mosi_o, far_mosi_oe, far_ss_n,
    input  miso
  );
endinterface
`default_nettype wire

// ==== src/spx_port.sv ====
// serial shift port: slave and master shift engine with transmit buffer
`include "spx_defines.svh"
`default_nettype none
module spx_port (
  input  wire logic               CLOCK,
  input  wire logic               ARST_N,
  input  wire logic               MASTER_SEL,
  input  wire logic               PORT_EN,
  input  wire logic               CLK_POL,
  input  wire logic               CLK_PHASE,
  input  wire logic               FAULT_EN,
  input  wire logic [1:0]         RATE_SEL,
  input  wire logic               WR_STB,
  input  wire spx_pkg::spx_byte_t WR_DATA,
  input  wire logic               RD_STATUS,
  input  wire logic               RD_DATA,
  input  wire logic               FAULT_CLR,
  output var  spx_pkg::spx_byte_t RX_DATA,
  output var  logic               RX_FULL,
  output var  logic               TX_EMPTY,
  output var  logic               MODE_FAULT,
  output var  logic               BUSY,
  spx_if.dev                      link
);
  import spx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: stage one feeds stage two only
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic [1:0] pin_s3_r;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_s1_r <= 4'hf;
      pin_s2_r <= 4'hf;
      pin_s3_r <= 2'h3;
    end else begin
      pin_s1_r <= {link.miso, link.mosi, link.ss_n, link.sck};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r[1:0];
    end
  end

  wire sck_s  = pin_s2_r[0];
  wire ss_s   = pin_s2_r[1];
  wire mosi_s = pin_s2_r[2];
  wire miso_s = pin_s2_r[3];
  wire sck_d  = pin_s3_r[0];
  wire ss_d   = pin_s3_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // mode decode
  wire slave_mode  = PORT_EN & ~MASTER_SEL;
  wire master_mode = PORT_EN & MASTER_SEL;

  logic      act_r;
  logic      pend_r;
  logic [4:0] ph_r;
  logic [6:0] div_r;
  logic [3:0] bits_r;
  logic       samp_r;
  spx_byte_t  sh_r;
  spx_byte_t  tx_buf_r;
  logic       tx_full_r;
  logic       stat_arm_r;

  // slave edges are taken from the synchronised clock, so the highest
  // usable slave clock is one level change per bus cycle
  wire sck_chg = sck_s ^ sck_d;
  wire s_sel   = slave_mode & ~ss_s;
  wire s_lead  = s_sel & sck_chg & (sck_s != CLK_POL);
  wire s_trail = s_sel & sck_chg & (sck_s == CLK_POL);
  wire ss_fall = slave_mode & ss_d & ~ss_s;
  wire ss_rise = slave_mode & ~ss_d & ss_s;

  ////////////////////////////////////////////////////////////////////////////
  // master bit clock divider
  logic [6:0] half_cnt;
  always_comb begin
    unique case (RATE_SEL)
      `SPX_RATE_BY2:   half_cnt = `SPX_HALF_BY2;
      `SPX_RATE_BY8:   half_cnt = `SPX_HALF_BY8;
      `SPX_RATE_BY32:  half_cnt = `SPX_HALF_BY32;
      `SPX_RATE_BY128: half_cnt = `SPX_HALF_BY128;
    endcase
  end

  wire        tick    = master_mode & (div_r == half_cnt - 7'h01);
  wire [6:0]  div_nxt = (!master_mode || tick) ? 7'h00 : div_r + 7'h01;
  wire [4:0]  ph_inc  = ph_r + 5'h01;
  wire        m_start = tick & pend_r & ~act_r;
  wire        m_lead  = (tick & act_r & ph_inc[0]) | (m_start & CLK_PHASE);
  wire        m_trail = tick & act_r & ~ph_inc[0];
  wire        m_fault = master_mode & FAULT_EN & ~ss_s;

  ////////////////////////////////////////////////////////////////////////////
  // shared shift sequencing
  wire lead    = s_lead | m_lead;
  wire trail   = s_trail | m_trail;
  wire s_start = CLK_PHASE ? (s_lead & ~act_r) : ss_fall;
  wire start   = s_start | m_start;
  wire in_bit  = master_mode ? miso_s : mosi_s;
  wire samp_ev = act_r & (CLK_PHASE ? trail : lead);
  wire shft_ev = act_r & (CLK_PHASE ? lead : trail);
  wire [3:0] bits_inc = bits_r + 4'h1;
  wire done_p1 = CLK_PHASE & samp_ev & (bits_inc == `SPX_BITS);
  wire done_p0 = ~CLK_PHASE & shft_ev & (bits_r == `SPX_BITS);
  wire done    = done_p1 | done_p0;
  wire s_abort = act_r & ss_rise;
  wire abort   = s_abort | m_fault | ~PORT_EN;
  wire load    = ~act_r & ~pend_r & tx_full_r;

  spx_byte_t sh_nxt;
  always_comb begin
    sh_nxt = sh_r;
    if (load) begin
      sh_nxt = tx_buf_r;
    end else if (done_p1) begin
      sh_nxt = {sh_r[6:0], in_bit};
    end else if (shft_ev) begin
      sh_nxt = {sh_r[6:0], samp_r};
    end
  end

  wire act_nxt  = abort ? 1'b0 : (start ? 1'b1 : (done ? 1'b0 : act_r));
  wire pend_nxt = ~master_mode ? 1'b0 : ((load & ~start) ? 1'b1 : (m_start ? 1'b0 : pend_r));
  wire [4:0] ph_nxt = (m_start & CLK_PHASE) ? 5'h01 :
                      (m_start ? 5'h00 : ((tick & act_r) ? ph_inc : ph_r));
  wire [3:0] bits_nxt = (start | done | abort) ? 4'h0 : (samp_ev ? bits_inc : bits_r);

  ////////////////////////////////////////////////////////////////////////////
  // sequencing state
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      act_r  <= 1'b0;
      pend_r <= 1'b0;
      ph_r   <= 5'h00;
      div_r  <= 7'h00;
      bits_r <= 4'h0;
      samp_r <= 1'b0;
      sh_r   <= 8'h00;
    end else begin
      act_r  <= act_nxt;
      pend_r <= pend_nxt;
      ph_r   <= ph_nxt;
      div_r  <= div_nxt;
      bits_r <= bits_nxt;
      samp_r <= samp_ev ? in_bit : samp_r;
      sh_r   <= sh_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit buffer and cpu side flags; a set in the same cycle wins
  wire rx_clr   = RD_DATA & stat_arm_r;
  wire fault_ev = (s_abort & FAULT_EN) | m_fault;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_buf_r   <= 8'h00;
      tx_full_r  <= 1'b0;
      stat_arm_r <= 1'b0;
      RX_DATA    <= 8'h00;
      RX_FULL    <= 1'b0;
      TX_EMPTY   <= 1'b1;
      MODE_FAULT <= 1'b0;
      BUSY       <= 1'b0;
    end else begin
      tx_buf_r   <= WR_STB ? WR_DATA : tx_buf_r;
      tx_full_r  <= WR_STB | (tx_full_r & ~load);
      TX_EMPTY   <= ~(WR_STB | (tx_full_r & ~load));
      stat_arm_r <= (RD_STATUS & RX_FULL) | (stat_arm_r & ~RD_DATA);
      RX_DATA    <= done ? sh_nxt : RX_DATA;
      RX_FULL    <= done | (RX_FULL & ~rx_clr);
      MODE_FAULT <= fault_ev | (MODE_FAULT & ~FAULT_CLR);
      BUSY       <= act_nxt | pend_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers
  wire m_active_lvl = act_nxt & ph_nxt[0] & master_mode;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      link.dev_sck_o   <= 1'b0;
      link.dev_sck_oe  <= 1'b0;
      link.dev_mosi_o  <= 1'b0;
      link.dev_mosi_oe <= 1'b0;
      link.dev_miso_o  <= 1'b0;
      link.dev_miso_oe <= 1'b0;
    end else begin
      link.dev_sck_o   <= CLK_POL ^ m_active_lvl;
      link.dev_sck_oe  <= master_mode;
      link.dev_mosi_o  <= sh_nxt[7];
      link.dev_mosi_oe <= master_mode;
      link.dev_miso_o  <= sh_nxt[7];
      link.dev_miso_oe <= slave_mode & ~ss_s;
    end
  end
endmodule
`default_nettype wire

// ==== src/spx_remote.sv ====
// remote master end: drives select, clock and data toward the port
`include "spx_defines.svh"
`default_nettype none
module spx_remote (
  input  wire logic               CLOCK,
  input  wire logic               ARST_N,
  input  wire logic               START,
  input  wire spx_pkg::spx_byte_t TX_BYTE,
  input  wire logic               CLK_POL,
  input  wire logic               CLK_PHASE,
  input  wire logic               KEEP_SEL,
  output var  spx_pkg::spx_byte_t RX_BYTE,
  output var  logic               DONE,
  output var  logic               BUSY,
  spx_if.far                      link
);
  import spx_pkg::*;

  logic        miso_s1_r;
  logic        miso_s2_r;
  spx_rstate_e st_r;
  logic [4:0]  cnt_r;
  logic [4:0]  ph_r;
  spx_byte_t   sh_r;
  spx_byte_t   rx_r;

  wire       expire  = (cnt_r == `SPX_FAR_HALF - 5'h01);
  wire [4:0] ph_inc  = ph_r + 5'h01;
  wire       lead    = (st_r == R_SHIFT) & expire & ph_inc[0];
  wire       trail   = (st_r == R_SHIFT) & expire & ~ph_inc[0];
  wire       samp    = CLK_PHASE ? trail : lead;
  wire       drive   = CLK_PHASE ? lead : trail;
  wire       hold_ss = KEEP_SEL & CLK_PHASE;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      miso_s1_r <= 1'b1;
      miso_s2_r <= 1'b1;
    end else begin
      miso_s1_r <= link.miso;
      miso_s2_r <= miso_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_r             <= R_IDLE;
      cnt_r            <= 5'h00;
      ph_r             <= 5'h00;
      sh_r             <= 8'h00;
      rx_r             <= 8'h00;
      RX_BYTE          <= 8'h00;
      DONE             <= 1'b0;
      BUSY             <= 1'b0;
      link.far_sck_o   <= 1'b0;
      link.far_sck_oe  <= 1'b0;
      link.far_mosi_o  <= 1'b0;
      link.far_mosi_oe <= 1'b0;
      link.far_ss_n    <= 1'b1;
    end else begin
      DONE             <= 1'b0;
      link.far_sck_oe  <= 1'b1;
      link.far_mosi_oe <= 1'b1;
      cnt_r            <= (st_r == R_IDLE || expire) ? 5'h00 : cnt_r + 5'h01;
      if (samp) begin
        rx_r <= {rx_r[6:0], miso_s2_r};
      end
      if (drive) begin
        link.far_mosi_o <= sh_r[7];
        sh_r            <= {sh_r[6:0], 1'b0};
      end
      unique case (st_r)
        R_IDLE: begin
          link.far_sck_o <= CLK_POL;
          if (START) begin
            link.far_ss_n   <= 1'b0;
            link.far_mosi_o <= TX_BYTE[7];
            sh_r            <= CLK_PHASE ? TX_BYTE : {TX_BYTE[6:0], 1'b0};
            BUSY            <= 1'b1;
            st_r            <= R_SETUP;
          end
        end
        R_SETUP: begin
          ph_r <= 5'h00;
          if (expire) begin
            st_r <= R_SHIFT;
          end
        end
        R_SHIFT: begin
          if (expire) begin
            ph_r           <= ph_inc;
            link.far_sck_o <= CLK_POL ^ ph_inc[0];
            if (ph_inc == `SPX_LAST_PH) begin
              st_r <= R_GAP;
            end
          end
        end
        R_GAP: begin
          if (expire) begin
            RX_BYTE <= rx_r;
            DONE    <= 1'b1;
            if (hold_ss) begin
              BUSY <= 1'b0;
              st_r <= R_IDLE;
            end else begin
              link.far_ss_n <= 1'b1;
              st_r          <= R_REL;
            end
          end
        end
        R_REL: begin
          if (expire) begin
            BUSY <= 1'b0;
            st_r <= R_IDLE;
          end
        end
        default: begin
          st_r <= R_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== verification/spx_link_properties.sv ====
// timing checks on the serial link between the port and the remote master
`default_nettype none
module spx_link_properties (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic dev_sck_oe,
  input wire logic dev_mosi_oe,
  input wire logic dev_miso_oe
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  logic [5:0] edge_cnt_r;
  ////////////////////////////////////////////////////////////////////////////
  // clock edges seen while selected; clears between selects
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) edge_cnt_r <= 6'h00;
    else if (ss_n) edge_cnt_r <= 6'h00;
    else if ($changed(sck)) edge_cnt_r <= edge_cnt_r + 6'h01;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_slave_no_drive: assert property (!dev_sck_oe && !dev_mosi_oe)
    else $error("slave drives clock or mosi");
  a_select_held_low: assert property ($fell(ss_n) |=> !ss_n [*8])
    else $error("select released too early");
  a_clock_half_period: assert property ($changed(sck) |=> $stable(sck) [*7])
    else $error("serial clock half period too short");
  a_miso_released: assert property (ss_n [*5] |-> !dev_miso_oe)
    else $error("miso driven while not selected");
  a_miso_oe_selected: assert property ($rose(dev_miso_oe) |-> !ss_n)
    else $error("miso drive began without select");
  a_miso_after_select: assert property ($fell(ss_n) |-> ##[1:6] dev_miso_oe)
    else $error("miso not driven after select fall");
  a_select_gap_high: assert property ($rose(ss_n) |=> ss_n [*7])
    else $error("select high gap too short");
  a_byte_edge_count: assert property ($rose(ss_n) |->
      edge_cnt_r[3:0] == 4'h0 && edge_cnt_r != 6'h00)
    else $error("select ended off a byte boundary");
  c_select: cover property ($fell(ss_n));
  c_miso_drive: cover property ($rose(dev_miso_oe));
  c_two_bytes: cover property (edge_cnt_r == 6'h20);
endmodule
`default_nettype wire

// ==== verification/spx_port_tb.sv ====
// self-checking bench: port against remote master, plus a lone port
`default_nettype none
module spx_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import spx_pkg::*;
  logic      clk = 1'b0, arst_n = 1'b0, pol = 1'b0, pha = 1'b0, en = 1'b0;
  logic      fault_en = 1'b1, wr = 1'b0, rds = 1'b0, rdd = 1'b0, mclr = 1'b0;
  logic      start = 1'b0, keep = 1'b0, msel_b = 1'b0, wr_b = 1'b0;
  logic      rx_full, tx_empty, done, mfault_b, busy_b, busy_a, busy_r;
  logic [1:0] rate_b = 2'h0;
  spx_byte_t wdata = 8'h00, tbyte = 8'h00, wdata_b = 8'h00;
  spx_byte_t rx_data, r_byte, rx_data_b;
  int        n_errors = 0, comparisons = 0;
  spx_if lk ();
  spx_if lb ();
  spx_port i_spx_port (.CLOCK(clk), .ARST_N(arst_n), .MASTER_SEL(1'b0), .PORT_EN(en),
    .CLK_POL(pol), .CLK_PHASE(pha), .FAULT_EN(fault_en), .RATE_SEL(2'h0), .WR_STB(wr),
    .WR_DATA(wdata), .RD_STATUS(rds), .RD_DATA(rdd), .FAULT_CLR(mclr), .RX_DATA(rx_data),
    .RX_FULL(rx_full), .TX_EMPTY(tx_empty), .MODE_FAULT(), .BUSY(busy_a), .link(lk));
  spx_remote i_spx_remote (.CLOCK(clk), .ARST_N(arst_n), .START(start), .TX_BYTE(tbyte),
    .CLK_POL(pol), .CLK_PHASE(pha), .KEEP_SEL(keep), .RX_BYTE(r_byte), .DONE(done),
    .BUSY(busy_r), .link(lk));
  spx_port i_spx_port_b (.CLOCK(clk), .ARST_N(arst_n), .MASTER_SEL(msel_b), .PORT_EN(en),
    .CLK_POL(pol), .CLK_PHASE(pha), .FAULT_EN(fault_en), .RATE_SEL(rate_b), .WR_STB(wr_b),
    .WR_DATA(wdata_b), .RD_STATUS(1'b0), .RD_DATA(1'b0), .FAULT_CLR(mclr),
    .RX_DATA(rx_data_b), .RX_FULL(), .TX_EMPTY(), .MODE_FAULT(mfault_b), .BUSY(busy_b),
    .link(lb));
  spx_link_properties i_spx_link_properties (.CLOCK(clk), .ARST_N(arst_n), .sck(lk.sck),
    .ss_n(lk.ss_n), .dev_sck_oe(lk.dev_sck_oe), .dev_mosi_oe(lk.dev_mosi_oe),
    .dev_miso_oe(lk.dev_miso_oe));
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (n_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk8(input string nm, input spx_byte_t exp, input spx_byte_t got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk1(input string nm, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_hi(ref logic s, input int lim, input string nm);
    int i;
    i = 0;
    while (s !== 1'b1 && i < lim) begin
      tk(1);
      i++;
    end
    chk1(nm, 1'b1, s);
  endtask
  // format bits only move with the port disabled
  task automatic mode(input logic p_pol, input logic p_pha);
    en = 1'b0;
    tk(1);
    pol = p_pol;
    pha = p_pha;
    tk(1);
    en = 1'b1;
    tk(12);
  endtask
  task automatic cpu_write(input spx_byte_t b);
    wr = 1'b1;
    wdata = b;
    tk(1);
    wr = 1'b0;
  endtask
  task automatic xstart(input spx_byte_t mb, input logic k);
    start = 1'b1;
    tbyte = mb;
    keep = k;
    tk(1);
    start = 1'b0;
    chk1("remote busy", 1'b1, busy_r);
  endtask
  task automatic xend(input spx_byte_t es, input spx_byte_t em);
    wait_hi(done, 400, "done");
    chk8("remote rx", es, r_byte);
    wait_hi(rx_full, 20, "rx_full");
    chk8("port rx", em, rx_data);
    rds = 1'b1;
    tk(1);
    rds = 1'b0;
    rdd = 1'b1;
    tk(1);
    rdd = 1'b0;
    tk(1);
    chk1("rx_full clear", 1'b0, rx_full);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_formats();
    for (int m = 0; m < 4; m++) begin
      mode(m[1], m[0]);
      cpu_write(spx_byte_t'(8'h96 + m));
      wait_hi(tx_empty, 8, "load");
      xstart(spx_byte_t'(8'h3c + m), 1'b0);
      xend(spx_byte_t'(8'h96 + m), spx_byte_t'(8'h3c + m));
    end
  endtask
  task automatic t_buffer();
    mode(1'b0, 1'b1);
    cpu_write(8'h5a);
    tk(3);
    xstart(8'hc3, 1'b1);
    tk(40);
    cpu_write(8'h69);
    tk(3);
    chk1("held in buffer", 1'b0, tx_empty);
    chk1("slave busy", 1'b1, busy_a);
    xend(8'h5a, 8'hc3);
    wait_hi(tx_empty, 20, "late load");
    chk1("select kept", 1'b0, lk.ss_n);
    xstart(8'h0f, 1'b0);
    xend(8'h69, 8'h0f);
    tk(10);
    xstart(8'hf0, 1'b0);
    xend(8'h0f, 8'hf0);
  endtask
  task automatic t_fault();
    mode(1'b0, 1'b0);
    for (int k = 1; k >= 0; k--) begin
      fault_en = k[0];
      lb.far_ss_n = 1'b0;
      tk(8);
      chk1("miso drive", 1'b1, lb.dev_miso_oe);
      lb.far_ss_n = 1'b1;
      tk(8);
      chk1("mode fault", k[0], mfault_b);
      chk1("miso free", 1'b0, lb.dev_miso_oe);
      mclr = 1'b1;
      tk(1);
      mclr = 1'b0;
      tk(1);
      chk1("fault clear", 1'b0, mfault_b);
    end
  endtask
  // lone port as master; miso floats to its pull-up so ff comes back
  task automatic t_master();
    int half, n, edges, first;
    logic last;
    fault_en = 1'b0;
    lb.far_sck_oe = 1'b0;
    lb.far_mosi_oe = 1'b0;
    msel_b = 1'b1;
    for (int r = 0; r < 4; r++) begin
      rate_b = r[1:0];
      half = 1 << (2 * r);
      // odd rate steps run phase one, even ones phase zero
      mode(1'b0, r[0]);
      tk(5);
      last = lb.sck;
      wr_b = 1'b1;
      wdata_b = 8'h33;
      tk(1);
      wr_b = 1'b0;
      n = 0;
      edges = 0;
      first = 0;
      while (n < 40 * half + 60 && !(n > 3 && busy_b === 1'b0)) begin
        tk(1);
        n++;
        if (lb.sck !== last) begin
          edges++;
          if (first == 0) first = n;
          last = lb.sck;
        end
      end
      tk(2);
      chk1("start delay", 1'b1, first > 0 && first <= 2 * half + 3);
      chk8("edge count", 8'h10, edges[7:0]);
      chk8("master rx", 8'hff, rx_data_b);
      chk1("master busy", 1'b0, busy_b);
    end
    // a master seeing its select pulled low must flag the clash
    fault_en = 1'b1;
    lb.far_ss_n = 1'b0;
    tk(4);
    chk1("master fault", 1'b1, mfault_b);
    lb.far_ss_n = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    lb.far_sck_oe = 1'b1;
    lb.far_sck_o = 1'b0;
    lb.far_mosi_oe = 1'b1;
    lb.far_mosi_o = 1'b0;
    lb.far_ss_n = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    arst_n = 1'b1;
    tk(20);
    t_formats();
    t_buffer();
    t_fault();
    t_master();
    final_report();
  end
  initial begin
    #300000;
    n_errors++;
    final_report();
  end
endmodule
`default_nettype wire
